/* rtl/sbu_top.sv */
// Shift and Boolean functional unit with its operand and count registers
`timescale 1ns/10ps
module sbu_top
	import sbu_pkg::*;
(
	input  logic                    clk_i,
	input  logic                    rst_b_i,
	input  logic                    issue_valid_i,
	input  logic [SBU_PARCEL_W-1:0] parcel_i,
	input  logic                    oper_load_i,
	input  logic [SBU_AW-1:0]       oper_load_addr_i,
	input  logic [SBU_WORD_W-1:0]   oper_load_data_i,
	input  logic                    count_load_i,
	input  logic [SBU_AW-1:0]       count_load_addr_i,
	input  logic [SBU_CNT_W-1:0]    count_load_data_i,
	input  logic [SBU_AW-1:0]       read_addr_i,
	output logic                    result_valid_o,
	output logic [SBU_AW-1:0]       result_addr_o,
	output logic [SBU_WORD_W-1:0]   result_data_o,
	output logic                    illegal_o,
	output logic [SBU_WORD_W-1:0]   read_data_o
);
	sbu_state_t state_reg;
	sbu_state_t state_next;

	sbu_shift_if sh ();

	logic [SBU_OP_W-1:0]   opcode;
	logic [SBU_AW-1:0]     dest_sel;
	logic [SBU_AW-1:0]     src1_sel;
	logic [SBU_AW-1:0]     src2_sel;
	logic [SBU_AMT_W-1:0]  immediate_shift_count;
	logic [SBU_WORD_W-1:0] destination_operand_register;
	logic [SBU_WORD_W-1:0] first_source_register;
	logic [SBU_WORD_W-1:0] second_source_register;
	logic [SBU_CNT_W-1:0]  shift_count_register;
	logic                  cnt_neg;
	logic [SBU_AMT_W-1:0]  cnt_mag;
	logic                  cnt_over;
	logic                  is_shift;
	logic                  is_known;
	logic [SBU_WORD_W-1:0] bool_res;

	// Parcel fields and operand fetch
	always_comb begin
		opcode   = parcel_i[SBU_OP_HI:SBU_OP_LO];
		dest_sel = parcel_i[SBU_DST_HI:SBU_DST_LO];
		src1_sel = parcel_i[SBU_SRC1_HI:SBU_SRC1_LO];
		src2_sel = parcel_i[SBU_SRC2_HI:SBU_SRC2_LO];
		immediate_shift_count = {src1_sel, src2_sel};
		destination_operand_register = state_reg.operand_file[dest_sel];
		first_source_register  = state_reg.operand_file[src1_sel];
		second_source_register = state_reg.operand_file[src2_sel];
		shift_count_register   = state_reg.count_file[src1_sel];
	end

	// Count decode: bits 11-16 never looked at
	always_comb begin
		cnt_neg  = shift_count_register[SBU_SIGN_BIT];
		cnt_mag  = cnt_neg ? ~shift_count_register[SBU_AMT_W-1:0] :
			shift_count_register[SBU_AMT_W-1:0];
		cnt_over = shift_count_register[SBU_OVR_HI:SBU_OVR_LO] !=
			{(SBU_OVR_HI-SBU_OVR_LO+1){cnt_neg}};
	end

	// Shifter setup per opcode
	always_comb begin
		sh.operand = second_source_register;
		sh.amount  = cnt_mag;
		sh.mode    = SBU_SH_ROT;
		is_shift   = 1'b1;
		unique case (opcode)
			SBU_OP_LIMM: begin
				sh.operand = destination_operand_register;
				sh.amount  = immediate_shift_count;
			end
			SBU_OP_RIMM: begin
				sh.operand = destination_operand_register;
				sh.amount  = immediate_shift_count;
				sh.mode    = SBU_SH_ARITH;
			end
			SBU_OP_LVAR: begin
				if (cnt_neg && cnt_over) begin
					sh.mode = SBU_SH_ZERO;
				end else if (cnt_neg) begin
					sh.mode = SBU_SH_ARITH;
				end
			end
			SBU_OP_RVAR: begin
				if (!cnt_neg && cnt_over) begin
					sh.mode = SBU_SH_ZERO;
				end else if (!cnt_neg) begin
					sh.mode = SBU_SH_ARITH;
				end else begin
					sh.mode = SBU_SH_ROT;
				end
			end
			default: begin
				is_shift = 1'b0;
			end
		endcase
	end

	sbu_shifter u_shifter (
		.sh (sh.shifter)
	);

	// Boolean results
	always_comb begin
		is_known = 1'b1;
		unique case (opcode)
			SBU_OP_OR: begin
				bool_res = first_source_register | second_source_register;
			end
			SBU_OP_ORN: begin
				bool_res = first_source_register | ~second_source_register;
			end
			SBU_OP_XOR: begin
				bool_res = first_source_register ^ second_source_register;
			end
			SBU_OP_XNOR: begin
				bool_res = first_source_register ^ ~second_source_register;
			end
			SBU_OP_AND: begin
				bool_res = first_source_register & second_source_register;
			end
			SBU_OP_ANDN: begin
				bool_res = first_source_register & ~second_source_register;
			end
			default: begin
				bool_res = SBU_WORD_RST;
				is_known = is_shift;
			end
		endcase
	end

	// Next state; an issued write beats a load to the same register
	always_comb begin
		state_next           = state_reg;
		state_next.res_valid = 1'b0;
		state_next.illegal   = 1'b0;
		state_next.read_data = state_reg.operand_file[read_addr_i];
		if (oper_load_i) begin
			state_next.operand_file[oper_load_addr_i] = oper_load_data_i;
		end
		if (count_load_i) begin
			state_next.count_file[count_load_addr_i] = count_load_data_i;
		end
		if (issue_valid_i) begin
			if (is_known) begin
				state_next.res_valid = 1'b1;
				state_next.res_addr  = dest_sel;
				state_next.res_data  = is_shift ? sh.result : bool_res;
				// Only the destination is written
				state_next.operand_file[dest_sel] = state_next.res_data;
			end else begin
				// Foreign opcodes leave every register alone
				state_next.illegal = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_reg.operand_file <= {SBU_NREG{SBU_WORD_RST}};
			state_reg.count_file   <= {SBU_NREG{SBU_CNT_RST}};
			state_reg.res_valid    <= 1'b0;
			state_reg.res_addr     <= '0;
			state_reg.res_data     <= SBU_WORD_RST;
			state_reg.illegal      <= 1'b0;
			state_reg.read_data    <= SBU_WORD_RST;
		end else begin
			state_reg <= state_next;
		end
	end

	assign result_valid_o = state_reg.res_valid;
	assign result_addr_o  = state_reg.res_addr;
	assign result_data_o  = state_reg.res_data;
	assign illegal_o      = state_reg.illegal;
	assign read_data_o    = state_reg.read_data;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);

	logic do_or;
	logic do_orn;
	logic do_xor;
	logic do_xnor;
	logic do_and;
	logic do_andn;
	logic do_rimm;
	logic do_limm;
	logic do_lvar;
	logic do_rvar;
	logic other_kept;
	logic [SBU_AMT_W-1:0]  neg_mag;
	logic [SBU_WORD_W-1:0] exp_neg_right;
	logic [SBU_WORD_W-1:0] exp_pos_right;

	always_comb begin
		do_or   = issue_valid_i && opcode == SBU_OP_OR;
		do_orn  = issue_valid_i && opcode == SBU_OP_ORN;
		do_xor  = issue_valid_i && opcode == SBU_OP_XOR;
		do_xnor = issue_valid_i && opcode == SBU_OP_XNOR;
		do_and  = issue_valid_i && opcode == SBU_OP_AND;
		do_andn = issue_valid_i && opcode == SBU_OP_ANDN;
		do_rimm = issue_valid_i && opcode == SBU_OP_RIMM;
		do_limm = issue_valid_i && opcode == SBU_OP_LIMM;
		do_lvar = issue_valid_i && opcode == SBU_OP_LVAR;
		do_rvar = issue_valid_i && opcode == SBU_OP_RVAR;
		other_kept = src1_sel != dest_sel && !oper_load_i;
		// Expected shifts built straight from the count's fields
		neg_mag       = ~shift_count_register[SBU_AMT_W-1:0];
		exp_neg_right = SBU_WORD_W'($signed(second_source_register) >>>
			neg_mag);
		exp_pos_right = SBU_WORD_W'($signed(second_source_register) >>>
			shift_count_register[SBU_AMT_W-1:0]);
	end

	a_or_result: assert property (do_or |=> result_valid_o &&
		result_data_o == ($past(first_source_register) |
		$past(second_source_register)))
		else $error("OR result wrong");
	a_orn_result: assert property (do_orn |=>
		result_data_o == ($past(first_source_register) |
		~$past(second_source_register)))
		else $error("OR-not result wrong");
	a_xor_result: assert property (do_xor |=>
		result_data_o == ($past(first_source_register) ^
		$past(second_source_register)))
		else $error("XOR result wrong");
	a_xnor_result: assert property (do_xnor |=>
		result_data_o == ~($past(first_source_register) ^
		$past(second_source_register)))
		else $error("XNOR result wrong");
	a_and_result: assert property (do_and |=>
		result_data_o == ($past(first_source_register) &
		$past(second_source_register)))
		else $error("AND result wrong");
	a_andn_result: assert property (do_andn |=>
		result_data_o == ($past(first_source_register) &
		~$past(second_source_register)))
		else $error("AND-not result wrong");
	a_fixed_right: assert property (do_rimm |=>
		result_addr_o == $past(dest_sel) && result_data_o ==
		SBU_WORD_W'($signed($past(destination_operand_register)) >>>
		$past(immediate_shift_count)))
		else $error("fixed right shift wrong");
	a_rotate_ones: assert property (do_limm |=>
		$countones(result_data_o) ==
		$countones($past(destination_operand_register)))
		else $error("rotate changed bit count");
	a_left_zero: assert property (do_lvar &&
		shift_count_register[SBU_SIGN_BIT] &&
		shift_count_register[SBU_OVR_HI:SBU_OVR_LO] != 5'h1F
		|=> result_data_o == SBU_WORD_RST)
		else $error("oversize left-form shift not zero");
	a_right_zero: assert property (do_rvar &&
		!shift_count_register[SBU_SIGN_BIT] &&
		shift_count_register[SBU_OVR_HI:SBU_OVR_LO] != 5'h00
		|=> result_data_o == SBU_WORD_RST)
		else $error("oversize right-form shift not zero");
	a_right_sign: assert property (do_rvar && !cnt_over &&
		!shift_count_register[SBU_SIGN_BIT] |=>
		result_data_o[SBU_WORD_W-1] ==
		$past(second_source_register[SBU_WORD_W-1]))
		else $error("sign not kept on right shift");
	a_neg_rotate: assert property (do_rvar &&
		shift_count_register[SBU_SIGN_BIT] |=>
		$countones(result_data_o) ==
		$countones($past(second_source_register)))
		else $error("negative count did not rotate");
	a_source_kept: assert property (issue_valid_i && other_kept |=>
		state_reg.operand_file[$past(src1_sel)] ==
		$past(first_source_register))
		else $error("source register disturbed");
	a_write_back: assert property (result_valid_o && !$past(oper_load_i)
		|-> state_reg.operand_file[result_addr_o] == result_data_o)
		else $error("destination not written");
	a_neg_right: assert property (do_lvar &&
		shift_count_register[SBU_SIGN_BIT] &&
		shift_count_register[SBU_OVR_HI:SBU_OVR_LO] == 5'h1F
		|=> result_data_o == $past(exp_neg_right))
		else $error("negative left-form count wrong");
	a_pos_right: assert property (do_rvar &&
		!shift_count_register[SBU_SIGN_BIT] &&
		shift_count_register[SBU_OVR_HI:SBU_OVR_LO] == 5'h00
		|=> result_data_o == $past(exp_pos_right))
		else $error("positive right-form shift wrong");
	a_pos_rotate: assert property (do_lvar &&
		!shift_count_register[SBU_SIGN_BIT] |=>
		$countones(result_data_o) ==
		$countones($past(second_source_register)))
		else $error("positive count did not rotate");
	a_one_answer: assert property (issue_valid_i |=>
		result_valid_o != illegal_o)
		else $error("issue not answered once");
	a_no_answer: assert property (!issue_valid_i |=>
		!result_valid_o && !illegal_o)
		else $error("answer without issue");
	a_count_kept: assert property (!count_load_i |=>
		state_reg.count_file == $past(state_reg.count_file))
		else $error("count register disturbed");

	c_var_left: cover property (do_lvar && cnt_neg && !cnt_over);
	c_var_right: cover property (do_rvar && !cnt_neg && !cnt_over);
	c_oversize: cover property ((do_lvar || do_rvar) && cnt_over);
	c_boolean: cover property (do_xnor ##1 do_andn);
endmodule

/* rtl/sbu_pkg.sv */
// Constants and types for the shift and Boolean unit
package sbu_pkg;
	localparam int SBU_WORD_W   = 60;
	localparam int SBU_CNT_W    = 18;
	localparam int SBU_NREG     = 8;
	localparam int SBU_AW       = 3;
	localparam int SBU_PARCEL_W = 15;
	localparam int SBU_AMT_W    = 6;
	localparam int SBU_OP_W     = 6;
	localparam int SBU_OP_HI    = 14;
	localparam int SBU_OP_LO    = 9;
	localparam int SBU_DST_HI   = 8;
	localparam int SBU_DST_LO   = 6;
	localparam int SBU_SRC1_HI  = 5;
	localparam int SBU_SRC1_LO  = 3;
	localparam int SBU_SRC2_HI  = 2;
	localparam int SBU_SRC2_LO  = 0;
	localparam int SBU_SIGN_BIT = 17;
	localparam int SBU_OVR_HI   = 10;
	localparam int SBU_OVR_LO   = 6;
	localparam logic [SBU_AMT_W-1:0] SBU_ROT_WRAP = 6'h3C;
	localparam logic [SBU_WORD_W-1:0] SBU_WORD_RST = 60'h0;
	localparam logic [SBU_CNT_W-1:0]  SBU_CNT_RST  = 18'h0;
	localparam logic [SBU_OP_W-1:0] SBU_OP_AND    = 6'h09;
	localparam logic [SBU_OP_W-1:0] SBU_OP_OR     = 6'h0A;
	localparam logic [SBU_OP_W-1:0] SBU_OP_XOR    = 6'h0B;
	localparam logic [SBU_OP_W-1:0] SBU_OP_ANDN   = 6'h0D;
	localparam logic [SBU_OP_W-1:0] SBU_OP_ORN    = 6'h0E;
	localparam logic [SBU_OP_W-1:0] SBU_OP_XNOR   = 6'h0F;
	localparam logic [SBU_OP_W-1:0] SBU_OP_LIMM   = 6'h10;
	localparam logic [SBU_OP_W-1:0] SBU_OP_RIMM   = 6'h11;
	localparam logic [SBU_OP_W-1:0] SBU_OP_LVAR   = 6'h12;
	localparam logic [SBU_OP_W-1:0] SBU_OP_RVAR   = 6'h13;

	typedef enum logic [2:0] {
		SBU_SH_ROT   = 3'h1,
		SBU_SH_ARITH = 3'h2,
		SBU_SH_ZERO  = 3'h4
	} sbu_shmode_t;

	typedef struct packed {
		logic [SBU_NREG-1:0][SBU_WORD_W-1:0] operand_file;
		logic [SBU_NREG-1:0][SBU_CNT_W-1:0]  count_file;
		logic                                res_valid;
		logic [SBU_AW-1:0]                   res_addr;
		logic [SBU_WORD_W-1:0]               res_data;
		logic                                illegal;
		logic [SBU_WORD_W-1:0]               read_data;
	} sbu_state_t;
endpackage

/* rtl/sbu_shift_if.sv */
// Interface between the unit core and its shifter
`timescale 1ns/10ps
interface sbu_shift_if;
	import sbu_pkg::*;
	logic [SBU_WORD_W-1:0] operand;
	logic [SBU_AMT_W-1:0]  amount;
	sbu_shmode_t           mode;
	logic [SBU_WORD_W-1:0] result;
	modport core (output operand, output amount, output mode, input result);
	modport shifter (input operand, input amount, input mode, output result);
endinterface

/* rtl/sbu_shifter.sv */
// Combinational 60-bit rotate / arithmetic right shifter
`timescale 1ns/10ps
module sbu_shifter
	import sbu_pkg::*;
(
	sbu_shift_if.shifter sh
);
	logic [SBU_AMT_W-1:0]    rot_amt;
	logic [2*SBU_WORD_W-1:0] rot_wide;

	// Rotation by 60..63 equals rotation by 0..3
	always_comb begin
		rot_amt = (sh.amount >= SBU_ROT_WRAP) ?
			sh.amount - SBU_ROT_WRAP : sh.amount;
		rot_wide = {sh.operand, sh.operand} << rot_amt;
		unique case (sh.mode)
			SBU_SH_ROT: begin
				sh.result = rot_wide[2*SBU_WORD_W-1:SBU_WORD_W];
			end
			SBU_SH_ARITH: begin
				sh.result = SBU_WORD_W'($signed(sh.operand) >>> sh.amount);
			end
			SBU_SH_ZERO: begin
				sh.result = SBU_WORD_RST;
			end
			default: begin
				sh.result = SBU_WORD_RST;
			end
		endcase
	end
endmodule

/* testbench/sbu_cpu_model.sv */
// Processor-side model: issues parcels and loads operand and count registers
`timescale 1ns/10ps
module sbu_cpu_model
	import sbu_pkg::*;
(
	input  wire logic                    clk_i,
	output logic                         issue_valid_o,
	output logic [SBU_PARCEL_W-1:0]      parcel_o,
	output logic                         oper_load_o,
	output logic [SBU_AW-1:0]            oper_load_addr_o,
	output logic [SBU_WORD_W-1:0]        oper_load_data_o,
	output logic                         count_load_o,
	output logic [SBU_AW-1:0]            count_load_addr_o,
	output logic [SBU_CNT_W-1:0]         count_load_data_o,
	output logic [SBU_AW-1:0]            read_addr_o
);
	initial begin
		issue_valid_o = 1'b0;
		parcel_o = '0;
		{oper_load_o, oper_load_addr_o, oper_load_data_o} = '0;
		{count_load_o, count_load_addr_o, count_load_data_o} = '0;
		read_addr_o = '0;
	end

	task automatic drive(input logic v, input logic [SBU_PARCEL_W-1:0] p,
		input logic [SBU_AW-1:0] ra);
		issue_valid_o = v;
		parcel_o = p;
		read_addr_o = ra;
	endtask

	// Released data lines show the inverse so stale values never match
	task automatic ld_op(input logic [SBU_AW-1:0] a,
		input logic [SBU_WORD_W-1:0] d);
		oper_load_o = 1'b1;
		oper_load_addr_o = a;
		oper_load_data_o = d;
		@(posedge clk_i);
		#1;
		oper_load_o = 1'b0;
		oper_load_data_o = ~d;
	endtask

	task automatic ld_cnt(input logic [SBU_AW-1:0] a,
		input logic [SBU_CNT_W-1:0] d);
		count_load_o = 1'b1;
		count_load_addr_o = a;
		count_load_data_o = d;
		@(posedge clk_i);
		#1;
		count_load_o = 1'b0;
		count_load_data_o = ~d;
	endtask
endmodule

/* testbench/shift_and_boolean_unit_test.sv */
// Self-checking bench for the shift and Boolean unit
`timescale 1ns/10ps
module shift_and_boolean_unit_test;
	import sbu_pkg::*;
	logic                    clk_i = 1'b0;
	logic                    rst_b_i = 1'b0;
	logic                    iv, ol, cl, rv, ill;
	logic [SBU_PARCEL_W-1:0] pa;
	logic [SBU_AW-1:0]       oa, ca, ra_w, radr;
	logic [SBU_WORD_W-1:0]   od, rdat, rdd;
	logic [SBU_CNT_W-1:0]    cd;
	int                      n_mismatch = 0;
	int                      num_checks = 0;
	int                      seed = 32'hB697;
	logic [SBU_WORD_W-1:0]   xm [8] = '{default: '0};
	logic [SBU_CNT_W-1:0]    cm [8] = '{default: '0};
	logic [SBU_WORD_W-1:0]   e_data = '0;
	logic [SBU_AW-1:0]       e_addr = '0;
	logic [SBU_OP_W-1:0]     ops [10] = '{SBU_OP_AND, SBU_OP_OR, SBU_OP_XOR,
		SBU_OP_ANDN, SBU_OP_ORN, SBU_OP_XNOR, SBU_OP_LIMM, SBU_OP_RIMM,
		SBU_OP_LVAR, SBU_OP_RVAR};
	logic [SBU_OP_W-1:0]     bad [4] = '{6'h00, 6'h0C, 6'h14, 6'h3F};
	// Sign, oversize and ignored-bit corners of the count
	logic [SBU_CNT_W-1:0]    cnts [8] = '{18'h0000A, 18'h3FFF9, 18'h3FFF5,
		18'h0003F, 18'h00040, 18'h3F83F, 18'h1F805, 18'h207C0};

	always #5 clk_i = ~clk_i;

	sbu_cpu_model u_cpu (.clk_i(clk_i), .issue_valid_o(iv), .parcel_o(pa),
		.oper_load_o(ol), .oper_load_addr_o(oa), .oper_load_data_o(od),
		.count_load_o(cl), .count_load_addr_o(ca), .count_load_data_o(cd),
		.read_addr_o(ra_w));

	sbu_top u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .issue_valid_i(iv),
		.parcel_i(pa), .oper_load_i(ol), .oper_load_addr_i(oa),
		.oper_load_data_i(od), .count_load_i(cl), .count_load_addr_i(ca),
		.count_load_data_i(cd), .read_addr_i(ra_w), .result_valid_o(rv),
		.result_addr_o(radr), .result_data_o(rdat), .illegal_o(ill),
		.read_data_o(rdd));

	task automatic chk(input logic [59:0] got, input logic [59:0] exp,
		input string what);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	function automatic logic [59:0] rol(input logic [59:0] v, input int n);
		logic [119:0] w;
		w = {v, v} << (n % 60);
		return w[119:60];
	endfunction

	function automatic logic [59:0] asr(input logic signed [59:0] v,
		input int n);
		return v >>> ((n > 59) ? 59 : n);
	endfunction

	task automatic step(input logic [SBU_PARCEL_W-1:0] p);
		logic [SBU_WORD_W-1:0] a, b, r, rd;
		logic [SBU_CNT_W-1:0]  c;
		logic [SBU_AMT_W-1:0]  m;
		logic [SBU_AW-1:0]     d, ra;
		logic                  s, ovr, ok;
		d = p[8:6];
		a = xm[p[5:3]];
		b = xm[p[2:0]];
		c = cm[p[5:3]];
		s = c[17];
		m = s ? ~c[5:0] : c[5:0];
		ovr = c[10:6] != {5{s}};
		ok = 1'b1;
		r = '0;
		case (p[14:9])
		SBU_OP_AND:  r = a & b;
		SBU_OP_OR:   r = a | b;
		SBU_OP_XOR:  r = a ^ b;
		SBU_OP_ANDN: r = a & ~b;
		SBU_OP_ORN:  r = a | ~b;
		SBU_OP_XNOR: r = a ^ ~b;
		SBU_OP_LIMM: r = rol(xm[d], p[5:0]);
		SBU_OP_RIMM: r = asr(xm[d], p[5:0]);
		SBU_OP_LVAR: r = !s ? rol(b, m) : ovr ? '0 : asr(b, m);
		SBU_OP_RVAR: r = s ? rol(b, m) : ovr ? '0 : asr(b, m);
		default:     ok = 1'b0;
		endcase
		ra = 3'($random(seed));
		rd = xm[ra];
		u_cpu.drive(1'b1, p, ra);
		@(posedge clk_i);
		#1;
		if (ok) begin
			xm[d] = r;
			e_data = r;
			e_addr = d;
		end
		chk(60'(rv), 60'(ok), "valid");
		chk(60'(ill), 60'(!ok), "illegal");
		chk(60'(radr), 60'(e_addr), "dest");
		chk(rdat, e_data, "result");
		chk(rdd, rd, "readback");
	endtask

	// Pulses must be gone one cycle later; registers read back unchanged
	task automatic idle();
		logic [SBU_AW-1:0]     ra;
		logic [SBU_WORD_W-1:0] rd;
		ra = 3'($random(seed));
		rd = xm[ra];
		u_cpu.drive(1'b0, '0, ra);
		@(posedge clk_i);
		#1;
		chk(60'(rv), '0, "valid idle");
		chk(60'(ill), '0, "illegal idle");
		chk(rdd, rd, "readback idle");
	endtask

	task automatic done(input string t);
		$display("Test %s finished", t);
	endtask

	task automatic complete_run();
		$display("Checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		#200000;
		n_mismatch++;
		$display("Error %0t run limit reached", $time);
		complete_run();
	end

	initial begin
		repeat (2) @(posedge clk_i);
		#1;
		chk({58'h0, rv, ill}, '0, "pulses in reset");
		chk(rdat | rdd, '0, "data in reset");
		repeat (2) @(posedge clk_i);
		#1;
		rst_b_i = 1'b1;
		for (int i = 0; i < 8; i++)
			idle();
		done("reset");
		for (int i = 0; i < 8; i++) begin
			xm[i] = 60'({$random(seed), $random(seed)});
			u_cpu.ld_op(3'(i), xm[i]);
			cm[i] = cnts[i];
			u_cpu.ld_cnt(3'(i), cm[i]);
		end
		xm[0] = 60'h4D3D80000000049;
		u_cpu.ld_op(3'h0, xm[0]);
		for (int o = 0; o < 6; o++)
			for (int i = 0; i < 4; i++)
				step({ops[o], 9'($random(seed))});
		idle();
		done("boolean");
		for (int j = 0; j < 8; j++) begin
			step({SBU_OP_LVAR, 3'($random(seed)), 3'(j), 3'($random(seed))});
			step({SBU_OP_RVAR, 3'($random(seed)), 3'(j), 3'($random(seed))});
		end
		idle();
		done("variable shift");
		for (int n = 0; n < 64; n++) begin
			step({SBU_OP_RIMM, 3'(n), 6'(n)});
			step({SBU_OP_LIMM, 3'(n + 1), 6'(n)});
		end
		idle();
		done("fixed shift");
		for (int i = 0; i < 4; i++) begin
			step({bad[i], 9'($random(seed))});
			idle();
		end
		done("refused opcode");
		for (int i = 0; i < 300; i++)
			step({ops[$unsigned($random(seed)) % 10], 9'($random(seed))});
		idle();
		done("random mix");
		complete_run();
	end
endmodule
